/* hdl/cmx_defines.svh */
// Constants for the multiply, OR and stack execution block
`ifndef CMX_DEFINES_SVH
`define CMX_DEFINES_SVH

// Opcodes handled by this block
`define CMX_OP_MUL_R 8'h84
`define CMX_OP_MUL_IR 8'h85
`define CMX_OP_MUL_IM 8'h86
`define CMX_OP_NEXT 8'h0F
`define CMX_OP_NOOP 8'hFF
`define CMX_OP_OR_WR 8'h42
`define CMX_OP_OR_WIR 8'h43
`define CMX_OP_OR_R 8'h44
`define CMX_OP_OR_IR 8'h45
`define CMX_OP_OR_IM 8'h46
`define CMX_OP_POP_R 8'h50
`define CMX_OP_POP_IR 8'h51
`define CMX_OP_USRD 8'h92

// Execution time of each instruction, in clock cycles
`define CMX_CYC_MUL 5'h16
`define CMX_CYC_NEXT 5'h0A
`define CMX_CYC_NOOP 5'h04
`define CMX_CYC_OR_W 5'h04
`define CMX_CYC_OR 5'h06
`define CMX_CYC_POP 5'h08
`define CMX_CYC_USRD 5'h08
`define CMX_CYC_OTHER 5'h01

// Stack pointer bytes inside the register file
`define CMX_SP_HIGH_ADDR 8'hD8
`define CMX_SP_LOW_ADDR 8'hD9

// Flag bit positions in the flag byte
`define CMX_FLAG_C 7
`define CMX_FLAG_Z 6
`define CMX_FLAG_S 5
`define CMX_FLAG_V 4
`define CMX_FLAG_D 3
`define CMX_FLAG_H 2

// Register indices above the register file (byte address is 4 x index)
`define CMX_IDX_FLAGS 10'h100
`define CMX_IDX_PC 10'h101
`define CMX_IDX_IPTR 10'h102
`define CMX_IDX_WBASE 10'h103
`define CMX_IDX_STATUS 10'h104

// Reset values
`define CMX_RST_FLAGS 8'h00
`define CMX_RST_PC 16'h0000
`define CMX_RST_IPTR 16'h0000
`define CMX_RST_WBASE 8'hC0

`endif

/* hdl/cmx_pkg.sv */
// Types shared by the execution block
package cmx_pkg;

  // One instruction as handed over by the fetch logic
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } cmx_instr_type;

  // Execution sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RUN
  } cmx_state_type;

endpackage

/* hdl/cmx_alu.sv */
// Multiply and OR datapath with flag update
`timescale 1ns/100ps
`include "cmx_defines.svh"

module cmx_alu (
  input wire logic mul_sel, // High for multiply, low for OR
  input wire logic [7:0] dst_val, // Destination operand
  input wire logic [7:0] src_val, // Source operand
  input wire logic [7:0] flags_in, // Current flag byte
  output logic [15:0] result, // Product or OR result
  output logic [7:0] flags_out // Flag byte after the operation
);

  ////////////////////////////////////////////////////////////////////////
  // Datapath
  wire logic [15:0] product;
  wire logic [7:0] ored;

  // Full 16-bit unsigned product
  assign product = 16'(dst_val) * 16'(src_val);
  assign ored = dst_val | src_val;
  assign result = mul_sel ? product : {8'h00, ored};

  ////////////////////////////////////////////////////////////////////////
  // Flags
  always_comb begin
    flags_out = flags_in;
    flags_out[`CMX_FLAG_Z] = (result == 16'h0000);
    flags_out[`CMX_FLAG_V] = 1'b0;
    if (mul_sel) begin
      flags_out[`CMX_FLAG_C] = (product > 16'h00FF);
      flags_out[`CMX_FLAG_S] = product[15];
    end else begin
      flags_out[`CMX_FLAG_S] = ored[7];
    end
  end

endmodule

/* hdl/cmx_wb_slave.sv */
// Classic Wishbone slave front end with registered answer
`timescale 1ns/100ps

module cmx_wb_slave (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic cyc, // Bus cycle
  input wire logic stb, // Strobe
  input wire logic we, // Write enable
  input wire logic [3:0] sel, // Byte selects
  input wire logic allow, // Register file free this cycle
  input wire logic [31:0] rd_data, // Read data for the current address
  output logic ack, // Acknowledge, one cycle
  output logic [31:0] dat_o, // Registered read data
  output logic wr_en // Write commit pulse
);

  wire logic take;

  // Take a request once, when the core is free
  assign take = cyc & stb & ~ack & allow;
  assign wr_en = take & we & sel[0];

  ////////////////////////////////////////////////////////////////////////
  // Answer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack <= take;
      if (take) begin
        dat_o <= we ? 32'h0000_0000 : rd_data;
      end
    end
  end

endmodule

/* hdl/cmx_exec.sv */
// Execution of multiply, OR, no-operation, threaded jump and stack pops
// What this block does
// - Source times even pair byte, 16-bit product to pair, 22 cycles.
// - Multiply sets carry when product exceeds 255, else clears it.
// - Multiply sets zero and sign from product, clears overflow, keeps D, H.
// - Threaded jump: PC from word at pointer, pointer plus two, 10 cycles.
// - No-operation takes 4 cycles and changes nothing.
// - OR stores source OR destination in destination; 4 or 6 cycles.
// - OR sets zero and sign from result, clears overflow, keeps C, D, H.
// - Stack pop loads destination from stack, then stack pointer plus one.
// - Stack pointer high byte at register D8, low byte at D9.
// - User pop loads destination via pointer register, then decrements it.
// - Multiply and OR leave source unchanged unless it is the destination.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
`include "cmx_defines.svh"

module cmx_exec #(
  parameter int ADR_W = 10 // Wishbone word address width
) (
  input wire logic SYS_CLK, // 40 MHz system clock
  input wire logic RESET, // Asynchronous reset, active high
  input wire logic WB_CYC_I, // Wishbone cycle
  input wire logic WB_STB_I, // Wishbone strobe
  input wire logic WB_WE_I, // Wishbone write enable
  input wire logic [ADR_W+1:2] WB_ADR_I, // Wishbone word address
  input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
  input wire logic [31:0] WB_DAT_I, // Wishbone write data
  output logic [31:0] WB_DAT_O, // Wishbone read data
  output logic WB_ACK_O, // Wishbone acknowledge
  input wire logic INSTR_VALID, // Instruction offered
  input wire cmx_pkg::cmx_instr_type INSTR, // Opcode and operand bytes
  output logic INSTR_READY, // Ready to accept an instruction
  output logic INSTR_DONE, // Instruction finished, one cycle
  output logic [15:0] PM_ADDR, // Program memory word address
  input wire logic [15:0] PM_DATA, // Program memory word
  output logic [15:0] PROG_COUNTER, // Program counter
  output logic [7:0] FLAGS // Flag byte
);

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] regf [0:255];
  cmx_pkg::cmx_state_type state;
  cmx_pkg::cmx_instr_type instr_q;
  logic [4:0] cnt;
  logic [15:0] iptr;
  logic [7:0] wbase;

  wire logic [7:0] op;
  wire logic [7:0] b1;
  wire logic [7:0] b2;
  wire logic is_mul;
  wire logic is_or;
  wire logic is_or_w;
  wire logic is_pop;
  wire logic is_usrd;
  wire logic is_next;
  wire logic src_imm;
  wire logic [7:0] imm_val;
  wire logic [7:0] wr_src;
  wire logic [7:0] wr_dst;
  wire logic [7:0] src_addr;
  wire logic [7:0] dst_addr;
  wire logic [7:0] dst_even;
  wire logic [7:0] src_val;
  wire logic [7:0] dst_val;
  wire logic [15:0] sp;
  wire logic [15:0] sp_inc;
  wire logic [7:0] uptr_dec;
  wire logic [4:0] cyc_need;
  wire logic start;
  wire logic fire;
  wire cmx_pkg::cmx_state_type next_state;
  wire logic [15:0] alu_result;
  wire logic [7:0] alu_flags;

  ////////////////////////////////////////////////////////////////////////
  // Instruction decode
  assign op = instr_q.opcode;
  assign b1 = instr_q.byte1;
  assign b2 = instr_q.byte2;
  assign is_mul = (op == `CMX_OP_MUL_R) || (op == `CMX_OP_MUL_IR)
    || (op == `CMX_OP_MUL_IM);
  assign is_or_w = (op == `CMX_OP_OR_WR) || (op == `CMX_OP_OR_WIR);
  assign is_or = is_or_w || (op == `CMX_OP_OR_R) || (op == `CMX_OP_OR_IR)
    || (op == `CMX_OP_OR_IM);
  assign is_pop = (op == `CMX_OP_POP_R) || (op == `CMX_OP_POP_IR);
  assign is_usrd = (op == `CMX_OP_USRD);
  assign is_next = (op == `CMX_OP_NEXT);

  // Cycle count per opcode
  assign cyc_need = is_mul ? `CMX_CYC_MUL
    : is_next ? `CMX_CYC_NEXT
    : (op == `CMX_OP_NOOP) ? `CMX_CYC_NOOP
    : (op == `CMX_OP_OR_WR) ? `CMX_CYC_OR_W
    : is_or ? `CMX_CYC_OR
    : is_pop ? `CMX_CYC_POP
    : is_usrd ? `CMX_CYC_USRD
    : `CMX_CYC_OTHER;

  ////////////////////////////////////////////////////////////////////////
  // Operand addressing
  assign wr_dst = {wbase[7:4], b1[7:4]};
  assign wr_src = {wbase[7:4], b1[3:0]};
  assign src_imm = (op == `CMX_OP_MUL_IM) || (op == `CMX_OP_OR_IM);
  // Immediate byte position differs between multiply and OR
  assign imm_val = (op == `CMX_OP_MUL_IM) ? b1 : b2;
  assign sp = {regf[`CMX_SP_HIGH_ADDR], regf[`CMX_SP_LOW_ADDR]};
  assign sp_inc = sp + 16'h0001;

  // Source location for every addressing mode
  assign src_addr = (op == `CMX_OP_MUL_R) ? b1
    : (op == `CMX_OP_MUL_IR) ? regf[b1]
    : (op == `CMX_OP_OR_WR) ? wr_src
    : (op == `CMX_OP_OR_WIR) ? regf[wr_src]
    : (op == `CMX_OP_OR_R) ? b1
    : (op == `CMX_OP_OR_IR) ? regf[b1]
    : is_pop ? sp[7:0]
    : is_usrd ? regf[b1]
    : 8'h00;

  // Destination location for every addressing mode
  assign dst_addr = is_or_w ? wr_dst
    : (op == `CMX_OP_OR_IM) ? b1
    : (op == `CMX_OP_POP_R) ? b1
    : (op == `CMX_OP_POP_IR) ? regf[b1]
    : b2;
  assign dst_even = {b2[7:1], 1'b0};
  assign src_val = src_imm ? imm_val : regf[src_addr];
  assign dst_val = is_mul ? regf[dst_even] : regf[dst_addr];
  assign uptr_dec = regf[b1] - 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // Datapath
  cmx_alu u_alu (
    .mul_sel(is_mul),
    .dst_val(dst_val),
    .src_val(src_val),
    .flags_in(FLAGS),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer control
  assign start = INSTR_VALID & INSTR_READY;
  assign fire = (state == cmx_pkg::ST_RUN) && (cnt == cyc_need);
  assign next_state = start ? cmx_pkg::ST_RUN
    : fire ? cmx_pkg::ST_IDLE
    : state;

  // Register file write ports, applied in order so later ones win
  wire logic we0;
  wire logic we1;
  wire logic we2;
  wire logic [7:0] wa0;
  wire logic [7:0] wa1;
  wire logic [7:0] wd0;
  wire logic [7:0] wd1;

  assign we0 = fire & (is_mul | is_or | is_pop | is_usrd);
  assign wa0 = is_mul ? dst_even : dst_addr;
  assign wd0 = is_mul ? alu_result[15:8]
    : is_or ? alu_result[7:0]
    : src_val;
  assign we1 = fire & (is_mul | is_pop | is_usrd);
  assign wa1 = is_mul ? (dst_even | 8'h01)
    : is_usrd ? b1
    : `CMX_SP_LOW_ADDR;
  assign wd1 = is_mul ? alu_result[7:0]
    : is_usrd ? uptr_dec
    : sp_inc[7:0];
  assign we2 = fire & is_pop;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone access
  wire logic wb_allow;
  wire logic wb_wr;
  wire logic in_file;
  wire logic [7:0] wb_idx;
  logic [31:0] rd_data;

  assign wb_allow = (state == cmx_pkg::ST_IDLE) & ~start;
  assign in_file = (WB_ADR_I[ADR_W+1:10] == '0);
  assign wb_idx = WB_ADR_I[9:2];

  // Read data selection
  always_comb begin
    rd_data = 32'h0000_0000;
    if (in_file) begin
      rd_data = {24'h00_0000, regf[wb_idx]};
    end else begin
      case (WB_ADR_I[ADR_W+1:2])
        `CMX_IDX_FLAGS: rd_data = {24'h00_0000, FLAGS};
        `CMX_IDX_PC: rd_data = {16'h0000, PROG_COUNTER};
        `CMX_IDX_IPTR: rd_data = {16'h0000, iptr};
        `CMX_IDX_WBASE: rd_data = {24'h00_0000, wbase};
        `CMX_IDX_STATUS: rd_data = {31'h0000_0000, ~INSTR_READY};
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  cmx_wb_slave u_wb (
    .clk(SYS_CLK),
    .rst(RESET),
    .cyc(WB_CYC_I),
    .stb(WB_STB_I),
    .we(WB_WE_I),
    .sel(WB_SEL_I),
    .allow(wb_allow),
    .rd_data(rd_data),
    .ack(WB_ACK_O),
    .dat_o(WB_DAT_O),
    .wr_en(wb_wr)
  );

  wire logic wr_flags;
  wire logic wr_pc;
  wire logic wr_iptr;
  wire logic wr_wbase;

  assign wr_flags = wb_wr && (WB_ADR_I[ADR_W+1:2] == `CMX_IDX_FLAGS);
  assign wr_pc = wb_wr && (WB_ADR_I[ADR_W+1:2] == `CMX_IDX_PC);
  assign wr_iptr = wb_wr && (WB_ADR_I[ADR_W+1:2] == `CMX_IDX_IPTR);
  assign wr_wbase = wb_wr && (WB_ADR_I[ADR_W+1:2] == `CMX_IDX_WBASE);

  ////////////////////////////////////////////////////////////////////////
  // Register file, no reset
  always_ff @(posedge SYS_CLK) begin
    if (wb_wr && in_file) begin
      regf[wb_idx] <= WB_DAT_I[7:0];
    end
    if (we0) begin
      regf[wa0] <= wd0;
    end
    if (we1) begin
      regf[wa1] <= wd1;
    end
    if (we2) begin
      regf[`CMX_SP_HIGH_ADDR] <= sp_inc[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state <= cmx_pkg::ST_IDLE;
      instr_q <= '0;
      cnt <= 5'h00;
      INSTR_READY <= 1'b1;
      INSTR_DONE <= 1'b0;
    end else begin
      state <= next_state;
      INSTR_READY <= (next_state == cmx_pkg::ST_IDLE);
      INSTR_DONE <= fire;
      if (start) begin
        instr_q <= INSTR;
        cnt <= 5'h01;
      end else if (state == cmx_pkg::ST_RUN) begin
        cnt <= cnt + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter, pointer, flags and working base
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      PROG_COUNTER <= `CMX_RST_PC;
      iptr <= `CMX_RST_IPTR;
      FLAGS <= `CMX_RST_FLAGS;
      wbase <= `CMX_RST_WBASE;
    end else begin
      if (fire && is_next) begin
        PROG_COUNTER <= PM_DATA;
        iptr <= iptr + 16'h0002;
      end else begin
        if (wr_pc) begin
          PROG_COUNTER <= WB_DAT_I[15:0];
        end
        if (wr_iptr) begin
          iptr <= WB_DAT_I[15:0];
        end
      end
      if (fire && (is_mul || is_or)) begin
        FLAGS <= alu_flags;
      end else if (wr_flags) begin
        FLAGS <= WB_DAT_I[7:0];
      end
      if (wr_wbase) begin
        wbase <= WB_DAT_I[7:0];
      end
    end
  end

  // Program memory is addressed by the pointer
  assign PM_ADDR = iptr;

endmodule

/* testbench/cmx_exec_asserts.sv */
// Port checker for the execution block, bound to its top module
`timescale 1ns/100ps

module cmx_exec_asserts (
  input wire logic SYS_CLK, // Clock
  input wire logic RESET, // Reset
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Strobe
  input wire logic WB_ACK_O, // Acknowledge
  input wire logic INSTR_VALID, // Offer
  input wire cmx_pkg::cmx_instr_type INSTR, // Instruction
  input wire logic INSTR_READY, // Idle
  input wire logic INSTR_DONE, // Finish pulse
  input wire logic [15:0] PM_ADDR, // Pointer
  input wire logic [15:0] PM_DATA, // Memory word
  input wire logic [15:0] PROG_COUNTER, // Program counter
  input wire logic [7:0] FLAGS // Flags
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  // Decode of the opcode taken this edge
  wire acc = INSTR_VALID && INSTR_READY;
  wire [7:0] op = INSTR.opcode;
  wire is_mul = acc && op inside {[8'h84:8'h86]};
  wire is_or4 = acc && op == 8'h42;
  wire is_or6 = acc && op inside {[8'h43:8'h46]};
  wire is_pop = acc && op inside {8'h50, 8'h51, 8'h92};

  // Opcode and flags held from the accepting edge
  logic [7:0] lop;
  logic [7:0] lfl;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      lop <= 8'h00;
      lfl <= 8'h00;
    end else if (acc) begin
      lop <= op;
      lfl <= FLAGS;
    end
  end
  wire d_mul = INSTR_DONE && lop inside {[8'h84:8'h86]};
  wire d_or = INSTR_DONE && lop inside {[8'h42:8'h46]};
  wire d_keep = INSTR_DONE && lop inside {8'h0F, 8'hFF, 8'h50, 8'h51, 8'h92};

  ////////////////////////////////////////////////////////////////////////////
  // Steps of an instruction
  sequence s_busy;
    !INSTR_READY && !INSTR_DONE;
  endsequence
  sequence s_fin;
    INSTR_DONE && INSTR_READY;
  endsequence

  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held over one cycle");
  a_ack_idle: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    && INSTR_READY && !INSTR_VALID |=> WB_ACK_O)
    else $error("idle bus request not answered");
  a_mul_timing: assert property (is_mul |-> ##23 s_fin)
    else $error("multiply length wrong");
  a_mul_flags: assert property (d_mul |-> !FLAGS[4]
    && FLAGS[3:2] == lfl[3:2] && !(FLAGS[7] && FLAGS[6])
    && (!FLAGS[5] || FLAGS[7]))
    else $error("multiply flags wrong");
  a_next_load: assert property (acc && op == 8'h0F |-> ##11
    PROG_COUNTER == $past(PM_DATA)
    && PM_ADDR == $past(PM_ADDR, 11) + 16'h0002)
    else $error("threaded jump wrong");
  a_noop_quiet: assert property (acc && op == 8'hFF |=>
    s_busy [*4] ##1 s_fin ##0 PROG_COUNTER == $past(PROG_COUNTER, 5))
    else $error("no-operation wrong");
  a_or_short: assert property (is_or4 |=> s_busy [*4] ##1 s_fin)
    else $error("short OR length wrong");
  a_or_long: assert property (is_or6 |=> s_busy [*6] ##1 s_fin)
    else $error("long OR length wrong");
  a_or_flags: assert property (d_or |-> !FLAGS[4]
    && FLAGS[7] == lfl[7] && FLAGS[3:2] == lfl[3:2])
    else $error("OR flags wrong");
  a_pop_timing: assert property (is_pop |=>
    s_busy [*8] ##1 s_fin)
    else $error("pop length wrong");
  a_flags_kept: assert property (d_keep |-> FLAGS == lfl)
    else $error("flags changed");
endmodule

bind cmx_exec cmx_exec_asserts u_chk (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .INSTR_VALID(INSTR_VALID),
  .INSTR(INSTR), .INSTR_READY(INSTR_READY), .INSTR_DONE(INSTR_DONE),
  .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA), .PROG_COUNTER(PROG_COUNTER),
  .FLAGS(FLAGS)
);

/* testbench/cmx_exec_tb.sv */
// Self-checking bench for the execution block
`timescale 1ns/100ps

module cmx_exec_tb;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic valid = 1'b0;
  cmx_pkg::cmx_instr_type ins = '0;
  logic [31:0] bus_out;
  logic [31:0] rd;
  logic ack;
  logic ready;
  logic done;
  logic [15:0] pm_addr;
  logic [15:0] pm_data;
  logic [15:0] pc;
  logic [7:0] flags;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  // Register file setup, address then value
  logic [15:0] init [20] = '{16'h0020, 16'h0209, 16'h0507, 16'h07FF,
    16'h20FF, 16'h1203, 16'h4008, 16'h4137, 16'h4280, 16'hC015, 16'hC12A,
    16'hC243, 16'h4300, 16'hC300, 16'h4400, 16'hD800, 16'hD9FF, 16'hFF55,
    16'h5152, 16'h6042};

  // Program memory model
  assign pm_data = pm_addr ^ 16'hA5A5;

  cmx_exec uut (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat),
    .WB_DAT_O(bus_out), .WB_ACK_O(ack), .INSTR_VALID(valid), .INSTR(ins),
    .INSTR_READY(ready), .INSTR_DONE(done), .PM_ADDR(pm_addr),
    .PM_DATA(pm_data), .PROG_COUNTER(pc), .FLAGS(flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #12.5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done;
    end
  end

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic bus cycle, held until ack
  task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Ack is sampled at the rising edge; only the hang guard ends a wait
    @(posedge SYS_CLK);
    while (ack !== 1'b1) begin
      @(posedge SYS_CLK);
    end
    rd = bus_out;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task rdc(input logic [9:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Offer one instruction, count cycles to its finish pulse
  task run(input logic [7:0] o, b1, b2, input int n);
    int k;
    @(posedge SYS_CLK);
    valid <= 1'b1;
    ins <= {o, b1, b2};
    // Hold the offer until ready is sampled high
    @(posedge SYS_CLK);
    while (ready !== 1'b1) begin
      @(posedge SYS_CLK);
    end
    valid <= 1'b0;
    k = 0;
    do begin
      @(posedge SYS_CLK);
      #1;
      k++;
    end while (done !== 1'b1 && k < 40);
    chk(k, n);
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge SYS_CLK);
    RESET <= 1'b0;
    // Reset values and an unmapped place
    rdc(10'h100, 8'h00);
    rdc(10'h101, 16'h0000);
    rdc(10'h103, 8'hC0);
    wb(1'b1, 10'h105, 8'h5A);
    rdc(10'h105, 8'h00);
    rdc(10'h104, 32'h0000_0000);
    $display("test reset done");
    foreach (init[i]) wb(1'b1, {2'b00, init[i][15:8]}, init[i][7:0]);
    wb(1'b1, 10'h100, 8'h0C);
    // Multiply by register and through pointer
    run(8'h84, 8'h02, 8'h00, 22);
    rdc(10'h000, 8'h01);
    rdc(10'h001, 8'h20);
    rdc(10'h002, 8'h09);
    rdc(10'h100, 8'h8C);
    run(8'h85, 8'h05, 8'h20, 22);
    rdc(10'h020, 8'hFE);
    rdc(10'h021, 8'h01);
    rdc(10'h007, 8'hFF);
    rdc(10'h100, 8'hAC);
    $display("test multiply done");
    // OR in every form, carry set beforehand
    run(8'h44, 8'h41, 8'h40, 6);
    rdc(10'h040, 8'h3F);
    rdc(10'h041, 8'h37);
    rdc(10'h100, 8'h8C);
    run(8'h46, 8'h42, 8'h01, 6);
    rdc(10'h042, 8'h81);
    rdc(10'h100, 8'hAC);
    run(8'h42, 8'h01, 8'h00, 4);
    rdc(10'h0C0, 8'h3F);
    rdc(10'h0C1, 8'h2A);
    run(8'h43, 8'h32, 8'h00, 6);
    rdc(10'h0C3, 8'h00);
    rdc(10'h100, 8'hCC);
    run(8'h45, 8'h05, 8'h44, 6);
    rdc(10'h044, 8'hFF);
    rdc(10'h100, 8'hAC);
    $display("test or done");
    // Immediate multiply clears carry
    run(8'h86, 8'h05, 8'h12, 22);
    rdc(10'h012, 8'h00);
    rdc(10'h013, 8'h0F);
    rdc(10'h100, 8'h0C);
    // Threaded jump, no-operation, unknown opcode
    wb(1'b1, 10'h102, 16'h0100);
    run(8'h0F, 8'h00, 8'h00, 10);
    rdc(10'h101, 16'hA4A5);
    rdc(10'h102, 16'h0102);
    chk(pm_addr, 16'h0102);
    chk(pc, 16'hA4A5);
    run(8'hFF, 8'h00, 8'h00, 4);
    rdc(10'h101, 16'hA4A5);
    rdc(10'h100, 8'h0C);
    run(8'h00, 8'h00, 8'h00, 1);
    $display("test jump done");
    // Stack pops with carry into high byte
    run(8'h50, 8'h50, 8'h00, 8);
    rdc(10'h050, 8'h55);
    rdc(10'h0D8, 8'h01);
    rdc(10'h0D9, 8'h00);
    run(8'h51, 8'h51, 8'h00, 8);
    rdc(10'h052, 8'h01);
    rdc(10'h0D9, 8'h01);
    run(8'h92, 8'h60, 8'h62, 8);
    rdc(10'h062, 8'h81);
    rdc(10'h060, 8'h41);
    rdc(10'h100, 8'h0C);
    chk(flags, 8'h0C);
    $display("test stack done");
    test_done;
  end
endmodule
